//--- hw/crf_defs.svh
// constants for the core register, flag and return stack block
// Overview of operation
// - accumulator also readable/writable at data address ffh
// - pointer registers at 80h and 81h
// - short direct registers at 82h and 83h
// - twelve bit instruction pointer, 4096 byte reach
// - ordinary step leaves pointer plus one
// - relative branch adds signed offset to pointer
// - jump and call load encoded target address
// - returns load pointer from stack top
// - three carry/zero pairs: main, irq, nonmaskable
// - interrupts switch pair, interrupt return restores previous
// - context switch leaves flag values untouched
// - only active context pair visible and writable
// - carry from arithmetic, bit test, rotate left
// - zero set when result equals zero
// - reset starts in nonmaskable context
// - six twelve bit stack levels, no pointer
// - push shifts levels deeper, pointer into first
// - pop moves first level out, shifts rest up
// - beyond six nestings oldest address is lost
// - return on empty stack continues sequentially
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_ADDR_PTR_ONE 8'h80
`define CRF_ADDR_PTR_TWO 8'h81
`define CRF_ADDR_SHORT_ONE 8'h82
`define CRF_ADDR_SHORT_TWO 8'h83
`define CRF_ADDR_ACC 8'hff
`define CRF_RESET_VECTOR 12'hffe
`define CRF_NMI_VECTOR 12'hffc
`define CRF_REG_RESET 8'h00
`define CRF_STACK_LEVELS 6
`endif

//--- hw/crf_pkg.sv
// types for the core register, flag and return stack block
package crf_pkg;
   // flag context, one code per flag pair
   typedef enum logic [1:0] {
      CRF_CTX_MAIN = 2'b00,
      CRF_CTX_IRQ = 2'b01,
      CRF_CTX_NMI = 2'b10
   } crf_ctx_t;
   // instruction pointer update source from the sequencer
   typedef enum logic [2:0] {
      CRF_PC_HOLD = 3'b000,
      CRF_PC_STEP = 3'b001,
      CRF_PC_REL = 3'b010,
      CRF_PC_JUMP = 3'b011,
      CRF_PC_CALL = 3'b100,
      CRF_PC_RET = 3'b101,
      CRF_PC_IRQ = 3'b110,
      CRF_PC_INTERRUPT_RETURN = 3'b111
   } crf_pc_op_t;
   // flag update kind
   typedef enum logic [2:0] {
      CRF_FL_NONE = 3'b000,
      CRF_FL_ARITH = 3'b001,
      CRF_FL_LOGIC = 3'b010,
      CRF_FL_BTEST = 3'b011,
      CRF_FL_ROTL = 3'b100
   } crf_fl_op_t;
   // sequencer request toward the program counter
   typedef struct packed {
      crf_pc_op_t op;
      logic [11:0] target;
      logic [7:0] offset;
      logic nmi;
   } crf_pc_req_t;
   // sequencer request toward the active flag pair
   typedef struct packed {
      crf_fl_op_t op;
      logic [7:0] result;
      logic carry_out;
      logic tested_bit;
   } crf_fl_req_t;
   // data space access
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crf_bus_t;
endpackage

//--- hw/crf_stack.sv
// six level hardware return stack with saturating depth
`timescale 1ns/1ps
`include "crf_defs.svh"
module crf_stack import crf_pkg::*; #(
   parameter int LEVELS = `CRF_STACK_LEVELS,
   parameter int AW = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // control
   input wire logic push,
   input wire logic pop,
   input wire logic [AW-1:0] push_data,
   // state
   output logic [AW-1:0] top,
   output logic empty,
   output logic [3:0] depth
);
   initial begin
      // the push check looks at the second level, so at least two are needed
      if (LEVELS < 2 || LEVELS > 15) $error("crf_stack: LEVELS out of range");
   end
   // storage levels, outside data space, no visible pointer
   logic [AW-1:0] lvl_r [LEVELS];
   logic [3:0] depth_r;
   assign top = lvl_r[0];
   assign empty = (depth_r == 4'h0);
   assign depth = depth_r;
   // shift register: push deeper, pop toward top
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < LEVELS; i++) lvl_r[i] <= '0;
      end else if (push) begin
         lvl_r[0] <= push_data;
         for (int i = 1; i < LEVELS; i++) lvl_r[i] <= lvl_r[i-1]; // last level lost
      end else if (pop && !empty) begin
         for (int i = 0; i < LEVELS - 1; i++) lvl_r[i] <= lvl_r[i+1];
      end
   end
   // depth counter saturates at both ends
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         depth_r <= 4'h0;
      end else if (push && depth_r != 4'(LEVELS)) begin
         depth_r <= depth_r + 4'h1; // stays deepest when full
      end else if (!push && pop && !empty) begin
         depth_r <= depth_r - 4'h1; // stays at top when empty
      end
   end
   stack_sat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      depth_r == 4'(LEVELS) && push |=> depth_r == 4'(LEVELS))
      else $error("stack depth left saturation");
   stack_push_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      push |=> lvl_r[0] == $past(push_data) && lvl_r[1] == $past(lvl_r[0]))
      else $error("push did not shift levels");
endmodule

//--- hw/crf_core_regs.sv
// core architectural state: data registers, pointer, flag banks, stack
`timescale 1ns/1ps
`include "crf_defs.svh"
module crf_core_regs import crf_pkg::*; #(
   parameter int PC_W = 12,
   parameter logic [PC_W-1:0] NMI_VEC = `CRF_NMI_VECTOR
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // data space bus
   input wire crf_bus_t bus,
   output logic [7:0] rdata,
   output logic hit,
   // accumulator port for the alu
   input wire logic acc_we,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc,
   // pointer registers for indirect addressing
   output logic [7:0] index_pointer_one,
   output logic [7:0] index_pointer_two,
   // program counter control
   input wire crf_pc_req_t pc_req,
   input wire logic [PC_W-1:0] irq_vector,
   output logic [PC_W-1:0] instruction_pointer,
   // flag control, active pair only
   input wire crf_fl_req_t fl_req,
   output logic carry,
   output logic zero,
   output crf_ctx_t ctx,
   output logic [3:0] stack_depth
);
   initial begin
      if (PC_W != 12) $error("crf_core_regs: PC_W must be 12");
   end

   // mapped byte registers
   logic [7:0] acc_r, ptr1_r, ptr2_r, sd1_r, sd2_r;
   // program counter
   logic [PC_W-1:0] pc_r, pc_nxt;
   // one flag pair per context
   logic main_carry, main_zero, irq_carry, irq_zero;
   logic nonmaskable_carry, nonmaskable_zero;
   logic carry_nxt, zero_nxt;
   // context stack: current and up to two saved contexts
   crf_ctx_t ctx_r, ctx_sv0_r, ctx_sv1_r;
   // stack side
   logic push, pop, stk_empty;
   logic [PC_W-1:0] stk_top;

   // address decode, continuous
   wire sel_acc = bus.addr == `CRF_ADDR_ACC;
   wire sel_p1 = bus.addr == `CRF_ADDR_PTR_ONE;
   wire sel_p2 = bus.addr == `CRF_ADDR_PTR_TWO;
   wire sel_s1 = bus.addr == `CRF_ADDR_SHORT_ONE;
   wire sel_s2 = bus.addr == `CRF_ADDR_SHORT_TWO;
   assign hit = sel_acc | sel_p1 | sel_p2 | sel_s1 | sel_s2;
   // read mux; unmapped addresses read zero and leave hit low
   assign rdata = sel_acc ? acc_r : sel_p1 ? ptr1_r : sel_p2 ? ptr2_r :
                  sel_s1 ? sd1_r : sel_s2 ? sd2_r : 8'h00;
   assign acc = acc_r;
   assign index_pointer_one = ptr1_r;
   assign index_pointer_two = ptr2_r;
   assign instruction_pointer = pc_r;
   assign ctx = ctx_r;

   // sign extension of the relative offset
   function automatic logic [PC_W-1:0] sext(input logic [7:0] o);
      sext = {{(PC_W-8){o[7]}}, o};
   endfunction

   // accumulator: alu port has priority over a bus write to ffh
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) acc_r <= `CRF_REG_RESET;
      else if (acc_we) acc_r <= acc_wdata;
      else if (bus.wr && sel_acc) acc_r <= bus.wdata;
   end
   // pointer and short direct registers, plain data space cells
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr1_r <= `CRF_REG_RESET;
         ptr2_r <= `CRF_REG_RESET;
         sd1_r <= `CRF_REG_RESET;
         sd2_r <= `CRF_REG_RESET;
      end else if (bus.wr) begin
         if (sel_p1) ptr1_r <= bus.wdata;
         if (sel_p2) ptr2_r <= bus.wdata;
         if (sel_s1) sd1_r <= bus.wdata;
         if (sel_s2) sd2_r <= bus.wdata;
      end
   end

   // stack strobes; the pushed address is the return point
   assign push = pc_req.op == CRF_PC_CALL || pc_req.op == CRF_PC_IRQ;
   assign pop = pc_req.op == CRF_PC_RET || pc_req.op == CRF_PC_INTERRUPT_RETURN;

   // next program counter by source
   always_comb begin
      case (pc_req.op)
         CRF_PC_HOLD: pc_nxt = pc_r;
         CRF_PC_STEP: pc_nxt = pc_r + 12'h001;
         CRF_PC_REL: pc_nxt = pc_r + sext(pc_req.offset);
         CRF_PC_JUMP: pc_nxt = pc_req.target;
         CRF_PC_CALL: pc_nxt = pc_req.target;
         CRF_PC_IRQ: pc_nxt = pc_req.nmi ? NMI_VEC : irq_vector;
         // empty stack: carry on with the next byte
         CRF_PC_RET, CRF_PC_INTERRUPT_RETURN: pc_nxt = stk_empty ? pc_r + 12'h001 : stk_top;
         default: pc_nxt = pc_r;
      endcase
   end
   // reset loads the reset vector as a constant
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) pc_r <= `CRF_RESET_VECTOR;
      else pc_r <= pc_nxt;
   end

   crf_stack #(.LEVELS(`CRF_STACK_LEVELS), .AW(PC_W)) u_stack (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .push(push),
      .pop(pop),
      .push_data(pc_r),
      .top(stk_top),
      .empty(stk_empty),
      .depth(stack_depth)
   );

   // context tracking: interrupt enters, interrupt return restores
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctx_r <= CRF_CTX_NMI;
         ctx_sv0_r <= CRF_CTX_MAIN;
         ctx_sv1_r <= CRF_CTX_MAIN;
      end else if (pc_req.op == CRF_PC_IRQ) begin
         ctx_r <= pc_req.nmi ? CRF_CTX_NMI : CRF_CTX_IRQ;
         ctx_sv0_r <= ctx_r;
         ctx_sv1_r <= ctx_sv0_r;
      end else if (pc_req.op == CRF_PC_INTERRUPT_RETURN) begin
         ctx_r <= ctx_sv0_r;
         ctx_sv0_r <= ctx_sv1_r;
         ctx_sv1_r <= CRF_CTX_MAIN;
      end
   end

   // active pair visible; others unreachable
   assign carry = ctx_r == CRF_CTX_MAIN ? main_carry :
                  ctx_r == CRF_CTX_IRQ ? irq_carry : nonmaskable_carry;
   assign zero = ctx_r == CRF_CTX_MAIN ? main_zero :
                 ctx_r == CRF_CTX_IRQ ? irq_zero : nonmaskable_zero;

   // flag update of the active pair
   always_comb begin
      carry_nxt = carry;
      zero_nxt = zero;
      case (fl_req.op)
         CRF_FL_ARITH: begin
            carry_nxt = fl_req.carry_out;
            zero_nxt = fl_req.result == 8'h00;
         end
         CRF_FL_LOGIC: zero_nxt = fl_req.result == 8'h00;
         CRF_FL_BTEST: carry_nxt = fl_req.tested_bit;
         CRF_FL_ROTL: begin
            carry_nxt = fl_req.carry_out; // msb out, old carry fed in by alu
            zero_nxt = fl_req.result == 8'h00;
         end
         default: ;
      endcase
   end
   // three banks; switching touches none of them
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         main_carry <= 1'b0;
         main_zero <= 1'b0;
         irq_carry <= 1'b0;
         irq_zero <= 1'b0;
         nonmaskable_carry <= 1'b0;
         nonmaskable_zero <= 1'b0;
      end else if (ctx_r == CRF_CTX_MAIN) begin
         main_carry <= carry_nxt;
         main_zero <= zero_nxt;
      end else if (ctx_r == CRF_CTX_IRQ) begin
         irq_carry <= carry_nxt;
         irq_zero <= zero_nxt;
      end else begin
         nonmaskable_carry <= carry_nxt;
         nonmaskable_zero <= zero_nxt;
      end
   end

   // checks
   pc_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_STEP |=> pc_r == $past(pc_r) + 12'h001)
      else $error("step did not add one");
   pc_jump_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_JUMP |=> pc_r == $past(pc_req.target))
      else $error("jump target not loaded");
   pc_ret_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_RET && !stk_empty |=> pc_r == $past(stk_top))
      else $error("return not from stack top");
   call_ret_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_CALL ##1 pc_req.op == CRF_PC_RET |=> pc_r == $past(pc_r, 2))
      else $error("call then return lost address");
   ctx_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_IRQ && !pc_req.nmi |=> ctx_r == CRF_CTX_IRQ)
      else $error("irq context not entered");
   ctx_interrupt_return_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pc_req.op == CRF_PC_IRQ ##1 pc_req.op == CRF_PC_INTERRUPT_RETURN |=> ctx_r == $past(ctx_r, 2))
      else $error("interrupt_return did not restore context");
   flag_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctx_r != CRF_CTX_MAIN |=> main_carry == $past(main_carry))
      else $error("inactive pair changed");
   zero_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      fl_req.op == CRF_FL_ARITH && pc_req.op == CRF_PC_STEP |=> zero == ($past(fl_req.result) == 8'h00))
      else $error("zero flag wrong");
   acc_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      bus.wr && sel_acc && !acc_we |=> acc_r == $past(bus.wdata))
      else $error("accumulator write at ffh lost");
   ptr_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      bus.wr && sel_p2 ##1 !bus.wr && bus.addr == `CRF_ADDR_PTR_TWO |-> rdata == $past(bus.wdata))
      else $error("pointer two readback wrong");
   cov_call: cover property (@(posedge ref_clk) pc_req.op == CRF_PC_CALL);
   cov_nmi: cover property (@(posedge ref_clk) pc_req.op == CRF_PC_IRQ && pc_req.nmi);
   cov_full: cover property (@(posedge ref_clk) stack_depth == 4'h6 && push);
   cov_empty_ret: cover property (@(posedge ref_clk) stk_empty && pop);
endmodule

//--- verification/crf_seq_model.sv
// behavioural core sequencer that issues one request set per core cycle
`timescale 1ns/1ps
module crf_seq_model import crf_pkg::*; (
   // clock
   ref_clk,
   // requests toward the register block
   bus,
   acc_we,
   acc_wdata,
   pc_req,
   fl_req,
   irq_vector
);
   input wire logic ref_clk;
   output crf_bus_t bus;
   output logic acc_we;
   output logic [7:0] acc_wdata;
   output crf_pc_req_t pc_req;
   output crf_fl_req_t fl_req;
   output logic [11:0] irq_vector;
   // idle requests so nothing acts while reset is held
   initial begin
      bus = '0;
      acc_we = 1'b0;
      acc_wdata = 8'h00;
      pc_req = '0;
      fl_req = '0;
      irq_vector = 12'h000;
   end
   // drive one full request set just after an edge and hold it over the next edge;
   // data registers are saved by the program itself, the stack keeps addresses only
   task automatic issue(input crf_bus_t b, input logic we, input logic [7:0] wd,
                        input crf_pc_req_t p, input crf_fl_req_t f, input logic [11:0] v);
      bus = b;
      acc_we = we;
      acc_wdata = wd;
      pc_req = p;
      fl_req = f;
      irq_vector = v;
      @(posedge ref_clk);
      #1;
   endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the core register, flag and return stack block
`timescale 1ns/1ps
module tb import crf_pkg::*;;
   logic ref_clk, reset_n, acc_we, hit, carry, zero;
   crf_bus_t bus;
   logic [7:0] acc_wdata, rdata, acc, ip1, ip2;
   crf_pc_req_t pc_req;
   crf_fl_req_t fl_req;
   logic [11:0] irq_vector, ip, epc;
   crf_ctx_t ctx, ectx;
   logic [3:0] depth;
   int miscompares, checks;
   logic [31:0] seed;
   logic [11:0] stk[$];
   crf_ctx_t cstk[$];
   logic fc[3];
   logic fz[3];
   logic [7:0] m[256];
   crf_seq_model seq (.ref_clk(ref_clk), .bus(bus), .acc_we(acc_we), .acc_wdata(acc_wdata),
      .pc_req(pc_req), .fl_req(fl_req), .irq_vector(irq_vector));
   crf_core_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
      .hit(hit), .acc_we(acc_we), .acc_wdata(acc_wdata), .acc(acc),
      .index_pointer_one(ip1), .index_pointer_two(ip2), .pc_req(pc_req),
      .irq_vector(irq_vector), .instruction_pointer(ip), .fl_req(fl_req), .carry(carry),
      .zero(zero), .ctx(ctx), .stack_depth(depth));
   // compare and count; unknowns never match
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // print counts and verdict, then stop
   task automatic tally_and_finish();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // pseudo random source with a fixed start
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected pointer after one request
   function automatic logic [11:0] nxt_pc(crf_pc_op_t op, logic [11:0] pc, logic [11:0] tgt,
                                          logic [7:0] off, logic [11:0] vec, logic [11:0] top);
      case (op)
         CRF_PC_HOLD: return pc;
         CRF_PC_REL: return pc + {{4{off[7]}}, off};
         CRF_PC_JUMP, CRF_PC_CALL: return tgt;
         CRF_PC_IRQ: return vec;
         CRF_PC_RET, CRF_PC_INTERRUPT_RETURN: return (stk.size() > 0) ? top : pc + 12'h001;
         default: return pc + 12'h001;
      endcase
   endfunction
   // one core cycle: update the model, issue, compare pointer, depth, context and flags
   task automatic act(input crf_pc_op_t op, input logic [11:0] tgt, input logic [7:0] off,
                      input logic nmi, input crf_fl_op_t fop, input logic [7:0] res,
                      input logic co, input logic tbit);
      logic [11:0] vec;
      logic [11:0] n;
      vec = nmi ? 12'hffc : {seed[11:1], 1'b0};
      n = nxt_pc(op, epc, tgt, off, vec, (stk.size() > 0) ? stk[0] : 12'h000);
      if (fop == CRF_FL_ARITH || fop == CRF_FL_ROTL || fop == CRF_FL_BTEST) begin
         fc[ectx] = (fop == CRF_FL_BTEST) ? tbit : co;
      end
      if (fop == CRF_FL_ARITH || fop == CRF_FL_ROTL || fop == CRF_FL_LOGIC) begin
         fz[ectx] = (res == 8'h00);
      end
      if (op == CRF_PC_CALL || op == CRF_PC_IRQ) begin
         stk.push_front(epc);
         if (stk.size() > 6) void'(stk.pop_back());
      end else if ((op == CRF_PC_RET || op == CRF_PC_INTERRUPT_RETURN) && stk.size() > 0) begin
         void'(stk.pop_front());
      end
      if (op == CRF_PC_IRQ) begin
         cstk.push_front(ectx);
         ectx = nmi ? CRF_CTX_NMI : CRF_CTX_IRQ;
      end else if (op == CRF_PC_INTERRUPT_RETURN && cstk.size() > 0) begin
         ectx = cstk.pop_front();
      end
      epc = n;
      seq.issue('0, 1'b0, 8'h00, '{op, tgt, off, nmi}, '{fop, res, co, tbit}, vec);
      chk(ip, epc);
      chk(depth, stk.size());
      chk(ctx, ectx);
      chk({carry, zero}, {fc[ectx], fz[ectx]});
   endtask
   // 25 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, far beyond the 127 cycles the tests need
   initial begin
      #(40 * 3000);
      miscompares++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      logic [7:0] a;
      logic [7:0] ad[6];
      miscompares = 0;
      checks = 0;
      seed = 32'hb4d3;
      epc = 12'hffe;
      ectx = CRF_CTX_NMI;
      fc = '{1'b0, 1'b0, 1'b0};
      fz = '{1'b0, 1'b0, 1'b0};
      ad = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
      reset_n = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      chk(ip, 12'hffe);
      chk(ctx, CRF_CTX_NMI);
      chk(depth, 4'h0);
      $display("test reset done");
      // mapped registers, then one unmapped address that must stay dead
      foreach (ad[i]) begin
         seed = lfsr(seed);
         a = ad[i];
         m[a] = (a == 8'h84) ? 8'h00 : seed[7:0];
         seq.issue('{1'b1, a, seed[7:0]}, 1'b0, 8'h00, '0, '0, 12'h000);
         chk(hit, a != 8'h84);
      end
      foreach (ad[i]) begin
         seq.issue('{1'b0, ad[i], 8'h00}, 1'b0, 8'h00, '0, '0, 12'h000);
         chk(rdata, m[ad[i]]);
      end
      chk({ip1, ip2, acc}, {m[8'h80], m[8'h81], m[8'hff]});
      // write pointer two, then read it back in the very next cycle
      seq.issue('{1'b1, 8'h81, 8'h5a}, 1'b0, 8'h00, '0, '0, 12'h000);
      seq.issue('{1'b0, 8'h81, 8'h00}, 1'b0, 8'h00, '0, '0, 12'h000);
      chk({rdata, ip2}, {8'h5a, 8'h5a});
      seq.issue('{1'b1, 8'hff, 8'h11}, 1'b1, 8'h22, '0, '0, 12'h000);
      chk({acc, rdata}, {8'h22, 8'h22});
      $display("test registers done");
      // seven nested calls overflow the six levels, then returns past empty
      for (int i = 0; i < 7; i++) act(CRF_PC_CALL, 12'(12'h200 + i * 16), 8'h00, 1'b0,
                                      CRF_FL_NONE, 8'h00, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++) act(CRF_PC_RET, 12'h000, 8'h00, 1'b0,
                                      CRF_FL_NONE, 8'h00, 1'b0, 1'b0);
      $display("test stack done");
      // flag banks across interrupt entry and return
      act(CRF_PC_HOLD, 12'h000, 8'h00, 1'b0, CRF_FL_ARITH, 8'h00, 1'b1, 1'b0);
      act(CRF_PC_IRQ, 12'h000, 8'h00, 1'b0, CRF_FL_NONE, 8'h00, 1'b0, 1'b0);
      act(CRF_PC_HOLD, 12'h000, 8'h00, 1'b0, CRF_FL_LOGIC, 8'h05, 1'b1, 1'b0);
      act(CRF_PC_IRQ, 12'h000, 8'h00, 1'b1, CRF_FL_BTEST, 8'h00, 1'b0, 1'b1);
      act(CRF_PC_HOLD, 12'h000, 8'h00, 1'b0, CRF_FL_ROTL, 8'h00, 1'b0, 1'b0);
      act(CRF_PC_INTERRUPT_RETURN, 12'h000, 8'h00, 1'b0, CRF_FL_NONE, 8'h00, 1'b0, 1'b0);
      act(CRF_PC_INTERRUPT_RETURN, 12'h000, 8'h00, 1'b0, CRF_FL_NONE, 8'h00, 1'b0, 1'b0);
      $display("test flags done");
      // random pointer and flag traffic
      repeat (80) begin
         seed = lfsr(seed);
         act(crf_pc_op_t'(seed[2:0] % 6), seed[30:19], seed[27:20], 1'b0,
             crf_fl_op_t'(seed[6:4] % 5), seed[15:8] & {8{seed[16]}}, seed[17], seed[18]);
      end
      $display("test random done");
      tally_and_finish();
   end
endmodule
